// *** logic/tmc_pkg.sv ***
// constants and types of the dual timer/counter block
// assumes one 125 MHz clock; registers on an APB slave port
package tmc_pkg;
   // byte offsets on the APB port
   localparam logic [7:0] OFS_CTRL = 8'h00;  // timer_control
   localparam logic [7:0] OFS_MODE = 8'h04;  // timer_mode_select
   localparam logic [7:0] OFS_CNT  = 8'h08;  // count_low_0 here, then high_0, low_1, high_1
   localparam logic [7:0] OFS_LAST = 8'h14;  // count_high_1
   // timer_control bit positions
   localparam int BIT_OVF_1  = 7;
   localparam int BIT_RUN_1  = 6;
   localparam int BIT_OVF_0  = 5;
   localparam int BIT_RUN_0  = 4;
   localparam int BIT_EDGE_1 = 3;
   localparam int BIT_TRIG_1 = 2;
   localparam int BIT_EDGE_0 = 1;
   localparam int BIT_TRIG_0 = 0;
   // timer_mode_select: one nibble per timer
   localparam int NIB_TMR_1 = 4;  // timer 1 nibble base
   localparam int FLD_GATE  = 3;
   localparam int FLD_SEL   = 2;  // 1 counts the event pin
   localparam int FLD_MODE  = 0;  // two bits
   // reset values
   localparam logic [7:0] CTRL_RST = 8'h00;
   localparam logic [7:0] MODE_RST = 8'h00;
   localparam logic [7:0] CNT_RST  = 8'h00;
   // one machine cycle is twelve clocks
   localparam int           MC_CLOCKS = 12;
   localparam logic [3:0]   MC_LAST   = 4'(MC_CLOCKS - 1);
   // counting modes
   typedef enum logic [1:0] {
      TMC_M13   = 2'b00,  // 13-bit with 5-bit prescaler
      TMC_M16   = 2'b01,  // 16-bit cascaded
      TMC_M8R   = 2'b10,  // 8-bit auto-reload
      TMC_SPLIT = 2'b11   // split / stop
   } tmc_mode_t;
   // whole module state; pin index 0 event_0, 1 event_1, 2 irq_0, 3 irq_1
   typedef struct packed {
      logic [7:0]      ctrl;    // timer_control
      logic [7:0]      mode;    // timer_mode_select
      logic [3:0][7:0] cnt;     // low_0, high_0, low_1, high_1
      logic [3:0]      sy1;     // synchroniser stage 1
      logic [3:0]      sy2;     // stage 2
      logic [3:0]      sy3;     // stage 3
      logic [3:0]      filt;    // accepted pin level
      logic [3:0]      smp;     // level at last machine cycle
      logic [3:0]      div;     // machine cycle divider
      logic [31:0]     prdata;  // read data
   } tmc_state_t;
endpackage

// *** logic/tmc_timer_counter.sv ***
// two 8-bit-pair timer/counters with run, gate, mode and flag logic
// assumes an APB master on clk_sys_in and asynchronous pins that are synchronised here
`timescale 1ns/10ps
`default_nettype none

module tmc_timer_counter (
   input  wire logic        clk_sys_in,        // 125 MHz clock
   input  wire logic        resetn_in,         // async reset, low
   input  wire logic        psel_in,           // apb select
   input  wire logic        penable_in,        // apb enable
   input  wire logic        pwrite_in,         // apb direction
   input  wire logic [7:0]  paddr_in,          // apb byte address
   input  wire logic [31:0] pwdata_in,         // apb write data
   output logic      [31:0] prdata_out,        // apb read data
   output logic             pready_out,        // apb ready
   output logic             pslverr_out,       // unmapped address
   input  wire logic        event_pin_0_in,    // timer 0 count pin
   input  wire logic        event_pin_1_in,    // timer 1 count pin
   input  wire logic        ext_irq_pin_0_in,  // irq 0 / gate 0 pin
   input  wire logic        ext_irq_pin_1_in,  // irq 1 / gate 1 pin
   input  wire logic [3:0]  irq_ack_in,        // vector pulses: ovf0, ovf1, edge0, edge1
   output logic      [3:0]  irq_req_out        // flags: ovf0, ovf1, edge0, edge1
);

   tmc_pkg::tmc_state_t r;       // registered state
   tmc_pkg::tmc_state_t next_r;  // next state
   logic        tick;            // machine cycle enable
   logic [3:0]  fall;            // falling sample per pin
   logic [1:0]  efall;           // irq pin falling edge
   logic        acc;             // apb access phase
   logic        wr;              // apb write taken
   logic        hit;             // mapped address
   logic [1:0]  m0;              // timer 0 mode
   logic [1:0]  m1;              // timer 1 mode
   logic        split;           // timer 0 in mode 3
   logic        inc0;            // timer 0 low step
   logic        inc1;            // timer 1 step
   logic        inch;            // split high byte step
   logic        ov0;             // timer 0 overflow
   logic        ov1;             // timer 1 overflow
   logic        ovh;             // split high overflow
   logic [16:0] s0;              // timer 0 step result
   logic [16:0] s1;              // timer 1 step result

   // one count step: {overflow, high, low}
   function automatic logic [16:0] step(
      input logic [1:0] m,
      input logic [7:0] hi,
      input logic [7:0] lo,
      input logic       inc
   );
      logic [13:0] s13;
      logic [16:0] s16;
      logic [8:0]  s8;
      logic [16:0] res;
      s13 = {1'b0, hi, lo[4:0]} + 14'(inc);
      s16 = {1'b0, hi, lo} + 17'(inc);
      s8  = {1'b0, lo} + 9'(inc);
      unique case (tmc_pkg::tmc_mode_t'(m))
         // upper three low bits stay as they were
         tmc_pkg::TMC_M13:   res = {s13[13], s13[12:5], lo[7:5], s13[4:0]};
         tmc_pkg::TMC_M16:   res = s16;
         tmc_pkg::TMC_M8R:   res = {s8[8], hi, (s8[8] ? hi : s8[7:0])};
         tmc_pkg::TMC_SPLIT: res = {s8[8], hi, s8[7:0]};
      endcase
      return res;
   endfunction

   // apb decode; zero wait states, read data caught in setup
   assign acc         = psel_in && penable_in;
   assign wr          = acc && pwrite_in;
   assign hit         = (paddr_in[1:0] == 2'b00) && (paddr_in <= tmc_pkg::OFS_LAST);
   assign pready_out  = acc;
   assign pslverr_out = acc && !hit;
   assign prdata_out  = r.prdata;
   assign irq_req_out = {r.ctrl[tmc_pkg::BIT_EDGE_1], r.ctrl[tmc_pkg::BIT_EDGE_0],
                         r.ctrl[tmc_pkg::BIT_OVF_1], r.ctrl[tmc_pkg::BIT_OVF_0]};

   // all next-state logic
   always_comb
   begin
      next_r = r;
      // machine cycle divider, one tick per twelve clocks
      tick       = (r.div == tmc_pkg::MC_LAST);
      next_r.div = tick ? 4'h0 : r.div + 4'h1;
      // three-stage synchronisers; stage one feeds only stage two
      next_r.sy1 = {ext_irq_pin_1_in, ext_irq_pin_0_in, event_pin_1_in, event_pin_0_in};
      next_r.sy2 = r.sy1;
      next_r.sy3 = r.sy2;
      for (int i = 0; i < 4; i++)
      begin
         // a level is accepted once two stages agree
         if (r.sy2[i] == r.sy3[i])
         begin
            next_r.filt[i] = r.sy3[i];
         end
      end
      // event pins are sampled once per machine cycle
      if (tick)
      begin
         next_r.smp = r.filt;
      end
      fall = {4{tick}} & r.smp & ~r.filt;
      // irq pin edge on the clock it is accepted
      for (int j = 0; j < 2; j++)
      begin
         efall[j] = r.filt[j + 2] && (r.sy2[j + 2] == r.sy3[j + 2]) && !r.sy3[j + 2];
      end
      // mode fields
      m0    = r.mode[tmc_pkg::FLD_MODE +: 2];
      m1    = r.mode[tmc_pkg::NIB_TMR_1 + tmc_pkg::FLD_MODE +: 2];
      split = (m0 == tmc_pkg::TMC_SPLIT);
      // timer 0 low part: run bit, gate, select
      inc0 = r.ctrl[tmc_pkg::BIT_RUN_0]
             && (!r.mode[tmc_pkg::FLD_GATE] || r.filt[2])
             && (r.mode[tmc_pkg::FLD_SEL] ? fall[0] : tick);
      // timer 1: while timer 0 is split it runs on mode and select alone, without run bit or gate
      inc1 = (split || (r.ctrl[tmc_pkg::BIT_RUN_1]
             && (!r.mode[tmc_pkg::NIB_TMR_1 + tmc_pkg::FLD_GATE] || r.filt[3])))
             && (m1 != tmc_pkg::TMC_SPLIT)
             && (r.mode[tmc_pkg::NIB_TMR_1 + tmc_pkg::FLD_SEL] ? fall[1] : tick);
      // split high byte: timer only, timer 1 run bit
      inch = split && r.ctrl[tmc_pkg::BIT_RUN_1] && tick;
      // counting never touches the count on start, only steps it
      s0  = step(m0, r.cnt[1], r.cnt[0], inc0);
      s1  = step(m1, r.cnt[3], r.cnt[2], inc1);
      ov0 = s0[16];
      ov1 = s1[16] && !split;
      ovh = inch && (r.cnt[1] == 8'hff);
      next_r.cnt[0] = s0[7:0];
      next_r.cnt[1] = split ? r.cnt[1] + 8'(inch) : s0[15:8];
      next_r.cnt[2] = s1[7:0];
      next_r.cnt[3] = s1[15:8];
      // vectoring clears flags; event sets below win
      if (irq_ack_in[0])
      begin
         next_r.ctrl[tmc_pkg::BIT_OVF_0] = 1'b0;
      end
      if (irq_ack_in[1])
      begin
         next_r.ctrl[tmc_pkg::BIT_OVF_1] = 1'b0;
      end
      if (irq_ack_in[2])
      begin
         next_r.ctrl[tmc_pkg::BIT_EDGE_0] = 1'b0;
      end
      if (irq_ack_in[3])
      begin
         next_r.ctrl[tmc_pkg::BIT_EDGE_1] = 1'b0;
      end
      // apb setup captures read data
      if (psel_in && !penable_in)
      begin
         next_r.prdata = 32'h0000_0000;
         if (paddr_in == tmc_pkg::OFS_CTRL)
         begin
            next_r.prdata[7:0] = r.ctrl;
         end
         else if (paddr_in == tmc_pkg::OFS_MODE)
         begin
            next_r.prdata[7:0] = r.mode;
         end
         else if (hit)
         begin
            next_r.prdata[7:0] = r.cnt[paddr_in[4:2] - 3'h2];
         end
      end
      // apb write: a software write beats a count step
      if (wr && hit)
      begin
         if (paddr_in == tmc_pkg::OFS_CTRL)
         begin
            next_r.ctrl = pwdata_in[7:0];
         end
         else if (paddr_in == tmc_pkg::OFS_MODE)
         begin
            next_r.mode = pwdata_in[7:0];
         end
         else
         begin
            next_r.cnt[paddr_in[4:2] - 3'h2] = pwdata_in[7:0];
         end
      end
      // hardware sets win over every clear
      if (ov0)
      begin
         next_r.ctrl[tmc_pkg::BIT_OVF_0] = 1'b1;
      end
      if (ov1 || ovh)
      begin
         next_r.ctrl[tmc_pkg::BIT_OVF_1] = 1'b1;
      end
      // type bit: 1 falling edge, 0 low level
      if (r.ctrl[tmc_pkg::BIT_TRIG_0] ? efall[0] : !r.filt[2])
      begin
         next_r.ctrl[tmc_pkg::BIT_EDGE_0] = 1'b1;
      end
      if (r.ctrl[tmc_pkg::BIT_TRIG_1] ? efall[1] : !r.filt[3])
      begin
         next_r.ctrl[tmc_pkg::BIT_EDGE_1] = 1'b1;
      end
   end

   // state register; reset leaves both timers stopped in mode 0
   always_ff @(posedge clk_sys_in or negedge resetn_in)
   begin
      if (!resetn_in)
      begin
         r      <= '0;
         r.ctrl <= tmc_pkg::CTRL_RST;
         r.mode <= tmc_pkg::MODE_RST;
         r.cnt  <= {4{tmc_pkg::CNT_RST}};
         // synchroniser stages rest high too: left at zero they would hand the filter a low that never was
         r.sy1  <= 4'hf;
         r.sy2  <= 4'hf;
         r.sy3  <= 4'hf;
         r.filt <= 4'hf;                                                    // pins idle high
         r.smp  <= 4'hf;
      end
      else
      begin
         r <= next_r;
      end
   end

   default clocking cb @(posedge clk_sys_in);
   endclocking
   default disable iff (!resetn_in);

   a_tick_period: assert property (tick |=> !tick [*8])
      else $error("machine cycle tick too frequent");
   a_ovf0_sets: assert property (ov0 |=> r.ctrl[tmc_pkg::BIT_OVF_0])
      else $error("timer 0 overflow lost");
   a_ovf0_ack: assert property (irq_ack_in[0] && !ov0 && !wr |=> !r.ctrl[tmc_pkg::BIT_OVF_0])
      else $error("overflow flag not cleared by vector");
   a_run_off_hold: assert property (!r.ctrl[tmc_pkg::BIT_RUN_0] && !wr |=> $stable(r.cnt[0]))
      else $error("stopped timer 0 moved");
   a_gate_low_hold: assert property (r.mode[tmc_pkg::FLD_GATE] && !r.filt[2] && !wr
      |=> $stable(r.cnt[0]))
      else $error("gated timer 0 moved");
   a_m0_upper_keep: assert property (m0 == tmc_pkg::TMC_M13 && !wr
      |=> r.cnt[0][7:5] == $past(r.cnt[0][7:5]))
      else $error("prescaler upper bits changed");
   a_m1_carry_up: assert property (inc0 && m0 == tmc_pkg::TMC_M16 && r.cnt[0] == 8'hff && !wr
      |=> r.cnt[0] == 8'h00 && r.cnt[1] == $past(r.cnt[1]) + 8'h01)
      else $error("16-bit carry wrong");
   a_m2_reload_hi: assert property (inc0 && m0 == tmc_pkg::TMC_M8R && r.cnt[0] == 8'hff && !wr
      |=> r.cnt[0] == $past(r.cnt[1]) && r.ctrl[tmc_pkg::BIT_OVF_0])
      else $error("auto-reload wrong");
   a_m3_t1_hold: assert property (m1 == tmc_pkg::TMC_SPLIT && !wr |=> $stable(r.cnt[3:2]))
      else $error("timer 1 moved in mode 3");
   a_split_hi_ovf: assert property (inch && r.cnt[1] == 8'hff && !wr
      |=> r.cnt[1] == 8'h00 && r.ctrl[tmc_pkg::BIT_OVF_1])
      else $error("split high overflow wrong");
   a_edge0_sets: assert property (r.ctrl[tmc_pkg::BIT_TRIG_0] && efall[0] |=> r.ctrl[tmc_pkg::BIT_EDGE_0])
      else $error("edge flag 0 missed");

   // timer 1, split high byte and their shared flag; write cycles left out except in a_ovf1_sets, a write wins over a step
   a_m2_reload_t1: assert property (inc1 && !split && m1 == tmc_pkg::TMC_M8R && r.cnt[2] == 8'hff && !wr
      |=> r.cnt[2] == $past(r.cnt[3]) && r.ctrl[tmc_pkg::BIT_OVF_1])
      else $error("timer 1 auto-reload wrong");
   a_ovf1_sets: assert property ((ov1 || ovh) |=> r.ctrl[tmc_pkg::BIT_OVF_1])
      else $error("timer 1 overflow lost");
   a_ovf1_ack: assert property (irq_ack_in[1] && !ov1 && !ovh && !wr |=> !r.ctrl[tmc_pkg::BIT_OVF_1])
      else $error("overflow flag 1 not cleared by vector");
   a_run1_off_hold: assert property (!split && !r.ctrl[tmc_pkg::BIT_RUN_1] && !wr |=> $stable(r.cnt[3:2]))
      else $error("stopped timer 1 moved");
   a_split_hi_off: assert property (split && !r.ctrl[tmc_pkg::BIT_RUN_1] && !wr |=> $stable(r.cnt[1]))
      else $error("split high byte moved without run bit");

   // mode 0 rollover and the pin side
   a_m0_wrap: assert property (inc0 && m0 == tmc_pkg::TMC_M13 && r.cnt[1] == 8'hff && r.cnt[0][4:0] == 5'h1f && !wr
      |=> r.cnt[1] == 8'h00 && r.cnt[0][4:0] == 5'h00 && r.ctrl[tmc_pkg::BIT_OVF_0])
      else $error("13-bit rollover wrong");
   a_edge1_sets: assert property (r.ctrl[tmc_pkg::BIT_TRIG_1] && efall[1] |=> r.ctrl[tmc_pkg::BIT_EDGE_1])
      else $error("edge flag 1 missed");
   a_level0_sets: assert property (!r.ctrl[tmc_pkg::BIT_TRIG_0] && !r.filt[2] |=> r.ctrl[tmc_pkg::BIT_EDGE_0])
      else $error("low level on irq pin 0 not flagged");
   a_pin_accept: assert property (r.sy2[0] == r.sy3[0] |=> r.filt[0] == $past(r.sy3[0]))
      else $error("count pin level not accepted");

endmodule

`default_nettype wire

// *** sim/tmc_pin_model.sv ***
// partner model: drives the count pins and the interrupt / gate pins of the timer block
// assumes the bench calls its tasks; pins rest high, as the filters expect at reset release
`timescale 1ns/10ps
`default_nettype none
module tmc_pin_model (
   input  wire logic       clk_sys_in,  // bench clock
   output logic      [1:0] event_out,   // count pins 0 and 1
   output logic      [1:0] irq_out      // interrupt / gate pins 0 and 1
);
   // idle high so no edge or low level is seen at reset release
   initial
   begin
      event_out = 2'h3;
      irq_out   = 2'h3;
   end
   // n falling transitions; each level held longer than one machine cycle so no sample misses it
   task automatic pulses(input int idx, input int n, input int hold);
      for (int i = 0; i < n; i++)
      begin
         repeat (hold) @(posedge clk_sys_in);
         event_out[idx] <= 1'b0;
         repeat (hold) @(posedge clk_sys_in);
         event_out[idx] <= 1'b1;
      end
   endtask
   // new level on an interrupt / gate pin, changed just after an edge
   task automatic set_irq(input int idx, input logic v);
      @(posedge clk_sys_in);
      irq_out[idx] <= v;
   endtask
endmodule
`default_nettype wire

// *** sim/dual_timer_counter_modes_tb_top.sv ***
// self-checking bench of the dual timer/counter: apb tasks, read scoreboard, pin partner
// assumes tmc_pkg, the timer block and the pin model are compiled first
`timescale 1ns/10ps
`default_nettype none
module dual_timer_counter_modes_tb_top;
   localparam logic [7:0] A_C  = tmc_pkg::OFS_CTRL;  // timer_control
   localparam logic [7:0] A_M  = tmc_pkg::OFS_MODE;  // timer_mode_select
   localparam logic [7:0] A_L0 = tmc_pkg::OFS_CNT;   // count_low_0
   localparam logic [7:0] A_H0 = A_L0 + 8'h04;       // count_high_0
   localparam logic [7:0] A_L1 = A_L0 + 8'h08;       // count_low_1
   localparam logic [7:0] A_H1 = A_L0 + 8'h0c;       // count_high_1
   logic        clk_sys_in = 1'b0;  // 125 MHz
   logic        resetn_in  = 1'b0;  // async, low
   logic        psel       = 1'b0;
   logic        penable    = 1'b0;
   logic        pwrite     = 1'b0;
   logic [7:0]  paddr      = 8'h00;
   logic [31:0] pwdata     = 32'h0;
   logic [3:0]  ack        = 4'h0;  // vector acknowledge pulses
   logic [31:0] prdata;
   logic        pready;
   logic        pslverr;
   logic [3:0]  req;
   logic [1:0]  ev;
   logic [1:0]  irq;
   logic [7:0]  rv;
   logic [32:0] exp_q[$];           // expected {pslverr, prdata} per read
   int          n_fail = 0;
   int          checked = 0;
   int          seed = 13953;
   int          n;

   tmc_timer_counter i_dut (.clk_sys_in(clk_sys_in), .resetn_in(resetn_in), .psel_in(psel),
      .penable_in(penable), .pwrite_in(pwrite), .paddr_in(paddr), .pwdata_in(pwdata),
      .prdata_out(prdata), .pready_out(pready), .pslverr_out(pslverr), .event_pin_0_in(ev[0]),
      .event_pin_1_in(ev[1]), .ext_irq_pin_0_in(irq[0]), .ext_irq_pin_1_in(irq[1]),
      .irq_ack_in(ack), .irq_req_out(req));
   tmc_pin_model i_pins (.clk_sys_in(clk_sys_in), .event_out(ev), .irq_out(irq));

   // 8 ns clock
   initial
   begin
      forever #4 clk_sys_in = ~clk_sys_in;
   end

   task automatic cmp_rd(input logic [32:0] got, input logic [32:0] e);
      checked++;
      if (got !== e)
      begin
         n_fail++;
         $display("wrong value at %0t: got %h expected %h", $time, got, e);
      end
   endtask
   // flags are looked at mid-cycle, once the edge's updates have landed
   task automatic cmp_irq(input logic [3:0] e);
      @(negedge clk_sys_in);
      cmp_rd({29'h0, req}, {29'h0, e});
   endtask

   // scoreboard: each completed read is checked against the oldest note
   always @(posedge clk_sys_in)
   begin
      if (psel && penable && pready && !pwrite)
      begin
         if (exp_q.size() == 0)
            n_fail++;
         else
            cmp_rd({pslverr, prdata}, exp_q.pop_front());
      end
   end

   // one apb transfer; the request stands until pready is sampled high
   task automatic xfer(input logic w, input logic [7:0] a, input logic [7:0] d, input logic [8:0] e);
      int t;
      t = 0;
      @(posedge clk_sys_in);
      psel    <= 1'b1;
      penable <= 1'b0;
      pwrite  <= w;
      paddr   <= a;
      pwdata  <= {24'h0, d};
      if (!w)
         exp_q.push_back({e[8], 24'h0, e[7:0]});
      @(posedge clk_sys_in);
      penable <= 1'b1;
      @(posedge clk_sys_in);
      while (pready !== 1'b1 && t < 20)
      begin
         t++;
         @(posedge clk_sys_in);
      end
      if (t >= 20)
         n_fail++;
      psel    <= 1'b0;
      penable <= 1'b0;
   endtask
   task automatic wr(input logic [7:0] a, input logic [7:0] d);
      xfer(1'b1, a, d, 9'h000);
   endtask
   task automatic rd(input logic [7:0] a, input logic [8:0] e);
      xfer(1'b0, a, 8'h00, e);
   endtask
   // run exactly k machine cycles: write edges sit 12k clocks apart (3 per transfer);
   // flags are checked before the stop write, which would overwrite them
   task automatic run_for(input logic [7:0] on, input logic [7:0] off, input int k, input logic [3:0] e);
      wr(A_C, on);
      repeat (tmc_pkg::MC_CLOCKS * k - 3) @(posedge clk_sys_in);
      cmp_irq(e);
      wr(A_C, off);
   endtask
   task automatic pulse_ack(input logic [3:0] m);
      @(posedge clk_sys_in);
      ack <= m;
      @(posedge clk_sys_in);
      ack <= 4'h0;
   endtask

   task automatic summarize();
      $display("checked %0d n_fail %0d", checked, n_fail);
      if (n_fail == 0 && checked > 0)
         $display("NO MISMATCHES");
      else
         $display("MISMATCHES SEEN");
      $finish;
   endtask

   // watchdog: the sequence needs at most about twelve hundred clocks
   initial
   begin
      repeat (20000) @(posedge clk_sys_in);
      n_fail++;
      summarize();
   end

   // main sequence
   initial
   begin
      repeat (16) @(posedge clk_sys_in);
      resetn_in <= 1'b1;
      rd(A_C, 9'h000);
      rd(A_M, 9'h000);
      rd(A_H1, 9'h000);
      rd(8'h18, 9'h100);
      rv = 8'($random(seed));
      wr(A_M, rv);
      rd(A_M, {1'b0, rv});
      // mode 1 from fffe: wraps to 0001 and flags
      wr(A_M, 8'h01);
      wr(A_L0, 8'hfe);
      wr(A_H0, 8'hff);
      run_for(8'h10, 8'h20, 3, 4'h1);
      rd(A_L0, 9'h001);
      rd(A_H0, 9'h000);
      rd(A_C, 9'h020);
      cmp_irq(4'h1);
      pulse_ack(4'h1);
      cmp_irq(4'h0);
      // mode 0: 13-bit 1ffe wraps to 0001, upper low bits left as written
      wr(A_M, 8'h00);
      wr(A_L0, 8'hfe);
      wr(A_H0, 8'hff);
      run_for(8'h10, 8'h20, 3, 4'h1);
      rd(A_L0, 9'h0e1);
      rd(A_H0, 9'h000);
      pulse_ack(4'h1);
      // mode 2 on both timers: fe, ff, reload, +1, +2; the stop write keeps only the timer 1 flag
      wr(A_M, 8'h22);
      wr(A_H0, 8'h80);
      wr(A_L0, 8'hfe);
      wr(A_H1, 8'hf0);
      wr(A_L1, 8'hfe);
      run_for(8'h50, 8'h80, 4, 4'h3);
      rd(A_L0, 9'h082);
      rd(A_H0, 9'h080);
      rd(A_L1, 9'h0f2);
      rd(A_H1, 9'h0f0);
      cmp_irq(4'h2);
      pulse_ack(4'h2);
      // split mode: high byte of timer 0 on run_bit_1, timer 1 holds
      wr(A_M, 8'h33);
      wr(A_L0, 8'h10);
      wr(A_H0, 8'hff);
      run_for(8'h50, 8'h80, 2, 4'h2);
      rd(A_L0, 9'h012);
      rd(A_H0, 9'h001);
      rd(A_L1, 9'h0f2);
      rd(A_C, 9'h080);
      pulse_ack(4'h2);
      // counter function: random number of falls on each count pin, one pin at a time
      n = 1 + ($unsigned($random(seed)) % 5);
      wr(A_M, 8'h55);
      wr(A_L0, 8'h00);
      wr(A_H0, 8'h00);
      wr(A_L1, 8'h00);
      wr(A_H1, 8'h00);
      wr(A_C, 8'h50);
      i_pins.pulses(0, n, 30);
      i_pins.pulses(1, n, 30);
      repeat (48) @(posedge clk_sys_in);
      wr(A_C, 8'h00);
      rd(A_L0, {1'b0, 8'(n)});
      rd(A_L1, {1'b0, 8'(n)});
      // gated timer: nothing while the pin is low, counts once it is high
      wr(A_M, 8'h09);
      wr(A_L0, 8'h00);
      i_pins.set_irq(0, 1'b0);
      repeat (8) @(posedge clk_sys_in);
      run_for(8'h10, 8'h00, 3, 4'h4);
      rd(A_L0, 9'h000);
      cmp_irq(4'h4);
      i_pins.set_irq(0, 1'b1);
      repeat (8) @(posedge clk_sys_in);
      pulse_ack(4'h4);
      cmp_irq(4'h0);
      run_for(8'h10, 8'h00, 3, 4'h0);
      rd(A_L0, 9'h003);
      // edge trigger: one fall flags once, acknowledge clears it though the pin stays low
      wr(A_C, 8'h05);
      i_pins.set_irq(0, 1'b0);
      repeat (8) @(posedge clk_sys_in);
      cmp_irq(4'h4);
      pulse_ack(4'h4);
      cmp_irq(4'h0);
      i_pins.set_irq(0, 1'b1);
      i_pins.set_irq(1, 1'b0);
      repeat (8) @(posedge clk_sys_in);
      cmp_irq(4'h8);
      pulse_ack(4'h8);
      cmp_irq(4'h0);
      i_pins.set_irq(1, 1'b1);
      summarize();
   end
endmodule
`default_nettype wire
